/* hdl/adc_result_trigger.sv */
// converter result registers, auto trigger and analog pin input disables
//
// Added by the designer: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
// Notes on behaviour
// - right aligned: result 9:8 in high bits 1:0, rest of high reads zero
// - left aligned: result 9:2 in high, 1:0 in low bits 7:6, rest zero
// - a conversion finishing while the pair is unlocked becomes visible in it; while locked it is dropped
// - reading the low byte freezes the pair until the high byte is read
// - trigger source field acts only while auto triggering is enabled
// - auto mode starts a conversion on a rising edge of the chosen flag
// - selecting a set flag other than the done flag after a clear one is an edge and starts
// - switching to free running never produces a trigger by itself
// - source codes: free, comparator, ext int 0, t0 A, t0 ovf, t1 B...
// - each set input-disable bit switches off that pin's input buffer
// - a disabled pin reads zero in the pin input register
// - alignment changes apply at once, even during a conversion
// - done flag sets when a result lands; it is the free-run source
module adc_result_trigger
   import adc_wrap_pkg::*;
#(
   parameter int PINS = 8
) (
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // register port
   input  wire reg_bus_s            bus,
   output byte_t                    rd_data,
   // converter core
   output logic                     conv_enable,
   output logic                     conv_start,
   output logic [CH_MUX_W-1:0]      chan_select,
   input  wire conv_done_s          conv_in,
   // on-chip trigger flags, codes 1 to 7
   input  wire logic [2**TRIG_W-1:1] trig_flags,
   // analog pins
   input  wire logic [PINS-1:0]     pin_raw,
   output logic [PINS-1:0]          pin_buffer_off,
   output logic [PINS-1:0]          pin_value,
   // interrupt
   output logic                     irq
);
   // refused at elaboration: the pin bits share one register byte
   if (PINS < 1 || PINS > BYTE_W) begin : g_pins_check
      $error("PINS must lie between 1 and one register width");
   end

   typedef struct packed {
      logic                  enable;
      logic                  auto_en;
      logic                  busy;
      logic                  done_flag;
      logic [CA_LOW_W-1:0]   ctrl_low;
      logic                  ref_sel;
      logic                  left;
      logic [CH_MUX_W-1:0]   mux;
      logic [TRIG_W-1:0]     trig_sel;
      logic                  cmux;
      logic [RESULT_W-1:0]   result;
      logic                  lock;
      logic [PINS-1:0]       pin_off;
      logic [IRQ_W-1:0]      irq_stat;
      logic [IRQ_W-1:0]      irq_mask;
      logic [PINS-1:0]       sync1;
      logic [PINS-1:0]       sync2;
      logic [PINS-1:0]       sync3;
      logic [PINS-1:0]       pin_stable;
      byte_t                 rdata;
      logic                  start_pulse;
   } main_s;

   main_s s_r;
   main_s s_nxt;

   byte_t                res_low;
   byte_t                res_high;
   logic                 trig_fire;
   logic [2**TRIG_W-1:0] trig_src;
   logic                 rd_low;
   logic                 rd_high;
   logic                 locked_now;
   logic                 sw_start;
   logic                 result_lands;
   byte_t                pin_byte;

   // left alignment is applied on the way out, so a change shows at once
   adc_result_format u_format (
      .result     (s_r.result),
      .left_align (s_r.left),
      .low_byte   (res_low),
      .high_byte  (res_high)
   );

   // the done flag is the free-running source, the rest come from outside
   assign trig_src = {trig_flags, s_r.done_flag};

   adc_trigger_edge u_trigger (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .flags    (trig_src),
      .sel      (s_r.trig_sel),
      .auto_en  (s_r.auto_en),
      .conv_en  (s_r.enable),
      .fire     (trig_fire)
   );

   assign rd_low   = bus.rd && (bus.addr == OFS_RES_LOW);
   assign rd_high  = bus.rd && (bus.addr == OFS_RES_HIGH);
   assign pin_byte = BYTE_W'(s_r.pin_stable & ~s_r.pin_off);

   always_comb begin
      s_nxt             = s_r;
      s_nxt.start_pulse = 1'b0;
      s_nxt.rdata       = RST_BYTE;
      sw_start          = 1'b0;

      // three-stage pin sampler; a change counts once stages two and three agree
      s_nxt.sync1 = pin_raw;
      s_nxt.sync2 = s_r.sync1;
      s_nxt.sync3 = s_r.sync2;
      for (int i = 0; i < PINS; i++) begin
         if (s_r.sync2[i] == s_r.sync3[i]) begin
            s_nxt.pin_stable[i] = s_r.sync3[i];
         end
      end

      // register writes; hardware sets below win over these clears
      if (bus.wr) begin
         unique case (bus.addr)
            OFS_CTRL_A: begin
               s_nxt.enable   = bus.wdata[CA_ENABLE];
               s_nxt.auto_en  = bus.wdata[CA_AUTO];
               s_nxt.ctrl_low = bus.wdata[CA_LOW_W-1:0];
               sw_start       = bus.wdata[CA_START];
               if (bus.wdata[CA_DONE]) begin
                  s_nxt.done_flag = 1'b0;
               end
            end
            OFS_CHAN: begin
               s_nxt.ref_sel = bus.wdata[CH_REF];
               s_nxt.left    = bus.wdata[CH_LEFT];
               s_nxt.mux     = bus.wdata[CH_MUX_W-1:0];
            end
            OFS_CTRL_B: begin
               // reserved bits are not stored and so read zero
               s_nxt.cmux     = bus.wdata[CB_CMUX];
               s_nxt.trig_sel = bus.wdata[TRIG_W-1:0];
            end
            OFS_PIN_OFF: begin
               s_nxt.pin_off = bus.wdata[PINS-1:0];
            end
            OFS_IRQ_STAT: begin
               s_nxt.irq_stat = s_r.irq_stat & ~bus.wdata[IRQ_W-1:0];
            end
            OFS_IRQ_MASK: begin
               s_nxt.irq_mask = bus.wdata[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // register reads; data stands in the following cycle only
      if (bus.rd) begin
         unique case (bus.addr)
            OFS_CTRL_A: begin
               s_nxt.rdata = {s_r.enable, s_r.busy, s_r.auto_en,
                              s_r.done_flag, s_r.ctrl_low};
            end
            OFS_CHAN: begin
               s_nxt.rdata = {1'b0, s_r.ref_sel, s_r.left, 1'b0, s_r.mux};
            end
            OFS_RES_LOW: begin
               s_nxt.rdata = res_low;
               s_nxt.lock  = 1'b1;
            end
            OFS_RES_HIGH: begin
               s_nxt.rdata = res_high;
               s_nxt.lock  = 1'b0;
            end
            OFS_CTRL_B: begin
               s_nxt.rdata = {1'b0, s_r.cmux, 3'h0, s_r.trig_sel};
            end
            OFS_PIN_OFF: begin
               s_nxt.rdata = BYTE_W'(s_r.pin_off);
            end
            OFS_IRQ_STAT: begin
               s_nxt.rdata = BYTE_W'(s_r.irq_stat);
            end
            OFS_IRQ_MASK: begin
               s_nxt.rdata = BYTE_W'(s_r.irq_mask);
            end
            OFS_PIN_IN: begin
               s_nxt.rdata = pin_byte;
            end
            default: begin
               s_nxt.rdata = RST_BYTE;
            end
         endcase
      end

      // a low read in this very cycle already counts as a lock, so the
      // byte just returned can never be paired with a newer high byte
      locked_now   = s_r.lock || rd_low;
      result_lands = conv_in.done && s_r.busy && !locked_now;

      // conversion end
      if (conv_in.done && s_r.busy) begin
         s_nxt.busy = 1'b0;
         if (!locked_now) begin
            s_nxt.result               = conv_in.value;
            s_nxt.done_flag            = 1'b1;
            s_nxt.irq_stat[IRQ_DONE]   = 1'b1;
         end else begin
            s_nxt.irq_stat[IRQ_DROP]   = 1'b1;
         end
      end

      // starting: software start or an auto trigger edge
      if (s_nxt.enable && !s_nxt.busy && (sw_start || trig_fire)) begin
         s_nxt.busy        = 1'b1;
         s_nxt.start_pulse = 1'b1;
      end

      // switching the converter off ends any conversion in flight
      if (!s_nxt.enable) begin
         s_nxt.busy = 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rd_data        = s_r.rdata;
   assign conv_enable    = s_r.enable;
   assign conv_start     = s_r.start_pulse;
   assign chan_select    = s_r.mux;
   assign pin_buffer_off = s_r.pin_off;
   assign pin_value      = s_r.pin_stable & ~s_r.pin_off;
   assign irq            = |(s_r.irq_stat & s_r.irq_mask);

   // checks on the behaviour above
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   align_right_a: assert property (
      rd_high && !s_r.left |=>
         rd_data == BYTE_W'($past(s_r.result) >> BYTE_W))
      else $error("right aligned high byte wrong");

   align_left_a: assert property (
      rd_low && s_r.left |=>
         rd_data == {$past(s_r.result[RESULT_W-BYTE_W-1:0]),
                     {(2*BYTE_W-RESULT_W){1'b0}}})
      else $error("left aligned low byte wrong");

   result_update_a: assert property (
      result_lands |=> s_r.result == $past(conv_in.value) && s_r.done_flag
         && s_r.irq_stat[IRQ_DONE])
      else $error("finished result not stored");

   lock_hold_a: assert property (
      s_r.lock && !rd_high |=> $stable(s_r.result))
      else $error("locked result pair changed");

   trig_gate_a: assert property (
      !s_r.auto_en |-> !trig_fire)
      else $error("trigger fired without auto mode");

   trig_edge_a: assert property (
      trig_fire |-> trig_src[s_r.trig_sel] && !$past(trig_src[s_r.trig_sel])
         && s_r.enable)
      else $error("trigger fired without a rising selected flag");

   trig_start_a: assert property (
      trig_fire && !s_r.busy && !(conv_in.done) && !bus.wr |=>
         conv_start && s_r.busy)
      else $error("trigger edge did not start a conversion");

   free_switch_a: assert property (
      s_r.trig_sel == TRIG_FREE && $past(s_r.trig_sel) != TRIG_FREE
         |-> !trig_fire)
      else $error("switch to free running triggered");

   pin_mask_a: assert property (
      (pin_value & s_r.pin_off) == '0)
      else $error("disabled pin reads non-zero");

   drop_locked_a: assert property (
      conv_in.done && s_r.busy && s_r.lock |=>
         $stable(s_r.result) && s_r.irq_stat[IRQ_DROP])
      else $error("locked pair overwritten");

   lock_set_a: assert property (
      rd_low |=> s_r.lock)
      else $error("low byte read did not lock the pair");

   lock_free_a: assert property (
      rd_high |=> !s_r.lock)
      else $error("high byte read did not unlock the pair");

   ctrl_b_rsv_a: assert property (
      bus.rd && bus.addr == OFS_CTRL_B |=>
         !rd_data[BYTE_W-1] && rd_data[CB_CMUX-1:TRIG_W] == '0)
      else $error("reserved control b bits read non-zero");

   start_pulse_a: assert property (
      conv_start |=> !conv_start)
      else $error("start pulse longer than one cycle");

   buf_off_a: assert property (
      bus.wr && bus.addr == OFS_PIN_OFF |=>
         pin_buffer_off == $past(bus.wdata[PINS-1:0]))
      else $error("input disable bits not applied");

   pin_read_a: assert property (
      bus.rd && bus.addr == OFS_PIN_IN |=>
         (rd_data & BYTE_W'($past(s_r.pin_off))) == '0)
      else $error("disabled pin read non-zero");

   align_write_a: assert property (
      bus.wr && bus.addr == OFS_CHAN |=>
         s_r.left == $past(bus.wdata[CH_LEFT]))
      else $error("alignment change not applied at once");

   done_set_a: assert property (
      $rose(s_r.done_flag) |-> $past(result_lands))
      else $error("done flag set without a stored result");

   free_src_a: assert property (
      s_r.auto_en && s_r.enable && $rose(s_r.done_flag)
         && s_r.trig_sel == TRIG_FREE && $past(s_r.trig_sel) == TRIG_FREE
         |-> trig_fire)
      else $error("done flag edge missed in free running");

   read_left_c: cover property (rd_high && s_r.left);
   drop_c:      cover property (conv_in.done && s_r.busy && s_r.lock);
   auto_trig_c: cover property (trig_fire && s_r.trig_sel != TRIG_FREE);
   free_run_c:  cover property (trig_fire && s_r.trig_sel == TRIG_FREE);
   switch_c:    cover property (
      trig_fire && s_r.trig_sel != $past(s_r.trig_sel));
endmodule

/* hdl/adc_wrap_pkg.sv */
// shared constants and carrier types of the converter result and trigger block
package adc_wrap_pkg;
   localparam int BYTE_W   = 8;
   localparam int RESULT_W = 10;
   localparam int TRIG_W   = 3;
   localparam int IRQ_W    = 2;

   typedef logic [BYTE_W-1:0] byte_t;

   // register offsets on the plain register port
   localparam byte_t OFS_CTRL_A   = 8'h00;
   localparam byte_t OFS_CHAN     = 8'h01;
   localparam byte_t OFS_RES_LOW  = 8'h02;
   localparam byte_t OFS_RES_HIGH = 8'h03;
   localparam byte_t OFS_CTRL_B   = 8'h04;
   localparam byte_t OFS_PIN_OFF  = 8'h05;
   localparam byte_t OFS_IRQ_STAT = 8'h06;
   localparam byte_t OFS_IRQ_MASK = 8'h07;
   localparam byte_t OFS_PIN_IN   = 8'h08;

   // field positions
   localparam int CA_ENABLE = 7;
   localparam int CA_START  = 6;
   localparam int CA_AUTO   = 5;
   localparam int CA_DONE   = 4;
   localparam int CA_LOW_W  = 4;
   localparam int CH_REF    = 6;
   localparam int CH_LEFT   = 5;
   localparam int CH_MUX_W  = 4;
   localparam int CB_CMUX   = 6;
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_DROP  = 1;

   localparam logic [TRIG_W-1:0] TRIG_FREE = 3'h0;
   localparam byte_t             RST_BYTE  = 8'h00;

   typedef struct packed {
      byte_t addr;
      byte_t wdata;
      logic  wr;
      logic  rd;
   } reg_bus_s;

   typedef struct packed {
      logic                done;
      logic [RESULT_W-1:0] value;
   } conv_done_s;
endpackage

/* hdl/adc_result_format.sv */
// places the raw conversion result into the high and low byte registers
`timescale 1ns/1ps
module adc_result_format
   import adc_wrap_pkg::*;
(
   // raw value and alignment
   input  wire logic [RESULT_W-1:0] result,
   input  wire logic                left_align,
   // presented bytes
   output byte_t                    low_byte,
   output byte_t                    high_byte
);
   // refused at elaboration: the split below needs more than one byte and at most two
   if (RESULT_W <= BYTE_W || RESULT_W > 2 * BYTE_W) begin : g_width_check
      $error("result width must lie between one and two bytes");
   end

   always_comb begin
      if (left_align) begin
         high_byte = result[RESULT_W-1:RESULT_W-BYTE_W];
         low_byte  = {result[RESULT_W-BYTE_W-1:0],
                      {(2*BYTE_W-RESULT_W){1'b0}}};
      end else begin
         high_byte = BYTE_W'(result[RESULT_W-1:BYTE_W]);
         low_byte  = result[BYTE_W-1:0];
      end
   end
endmodule

/* hdl/adc_trigger_edge.sv */
// rising-edge detector on the selected auto-trigger flag
`timescale 1ns/1ps
module adc_trigger_edge
   import adc_wrap_pkg::*;
(
   // clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 rst_n,
   // sources and selection
   input  wire logic [2**TRIG_W-1:0] flags,
   input  wire logic [TRIG_W-1:0]    sel,
   input  wire logic                 auto_en,
   input  wire logic                 conv_en,
   // trigger event
   output logic                      fire
);
   typedef struct packed {
      logic              prev;
      logic [TRIG_W-1:0] sel_prev;
   } edge_s;

   edge_s s_r;
   edge_s s_nxt;
   logic  cur;
   logic  to_free;

   always_comb begin
      s_nxt = s_r;
      // index into flags follows the source code table
      cur = flags[sel];
      // switching into free running must not look like an edge
      to_free = (sel == TRIG_FREE) && (s_r.sel_prev != TRIG_FREE);
      // a switch from a clear source to a set one other than free running is a real edge
      fire = auto_en && conv_en && cur && !s_r.prev && !to_free;
      s_nxt.prev     = cur;
      s_nxt.sel_prev = sel;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
endmodule

/* testbench/conv_core_model.sv */
// behavioural converter core answering start pulses with done and a value
`timescale 1ns/1ps
module conv_core_model
   import adc_wrap_pkg::*;
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                rst_n,
   // control from the block
   input  wire logic                conv_enable,
   input  wire logic                conv_start,
   // latency and value chosen by the bench
   input  wire logic [3:0]          lat,
   input  wire logic [RESULT_W-1:0] val,
   // answer
   output conv_done_s               conv_in
);
   int                  cnt;
   logic [RESULT_W-1:0] last;

   // outside the done pulse the value bus alternates between the inverse of the last result and the result itself
   always_ff @(posedge core_clk) begin
      conv_in.done  <= 1'b0;
      conv_in.value <= ~last;
      last          <= ~last;
      if (!rst_n) begin
         cnt  <= 0;
         last <= '0;
      end else if (!conv_enable) begin
         cnt <= 0;
      end else if (conv_start) begin
         cnt <= int'(lat) + 1;
      end else if (cnt == 1) begin
         cnt           <= 0;
         conv_in.done  <= 1'b1;
         conv_in.value <= val;
         last          <= val;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end
   end
endmodule

/* testbench/adc_result_and_trigger_regs_test.sv */
// self-checking bench of the converter result and trigger block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
   samples_checked++; \
   if ((g) !== (e)) begin \
      mismatches++; \
      $display("ERROR %s exp %0h got %0h", nm, e, g); \
   end \
end
module adc_result_and_trigger_regs_test
   import adc_wrap_pkg::*;
;
   logic                core_clk;
   logic                rst_n;
   reg_bus_s            bus;
   byte_t               rd_data;
   logic                conv_enable;
   logic                conv_start;
   logic [CH_MUX_W-1:0] chan_select;
   conv_done_s          conv_in;
   logic [7:1]          trig_flags;
   logic [7:0]          pin_raw;
   logic [7:0]          pin_buffer_off;
   logic [7:0]          pin_value;
   logic                irq;
   logic [3:0]          lat;
   logic [RESULT_W-1:0] val;
   byte_t               d;
   int                  mismatches = 0;
   int                  samples_checked = 0;
   int                  starts = 0;

   adc_result_trigger #(.PINS(8)) dut (
      .core_clk(core_clk), .rst_n(rst_n), .bus(bus), .rd_data(rd_data),
      .conv_enable(conv_enable), .conv_start(conv_start),
      .chan_select(chan_select), .conv_in(conv_in),
      .trig_flags(trig_flags), .pin_raw(pin_raw),
      .pin_buffer_off(pin_buffer_off), .pin_value(pin_value), .irq(irq));

   conv_core_model core (
      .core_clk(core_clk), .rst_n(rst_n), .conv_enable(conv_enable),
      .conv_start(conv_start), .lat(lat), .val(val), .conv_in(conv_in));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      if (conv_start === 1'b1) begin
         starts <= starts + 1;
      end
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      stop_test;
   end

   task stop_test;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   function automatic logic [15:0] fmt(input logic [RESULT_W-1:0] v,
                                       input logic l);
      return l ? {v, 6'h00} : {6'h00, v};
   endfunction

   task wr(input byte_t a, input byte_t v);
      @(posedge core_clk);
      bus.addr  <= a;
      bus.wdata <= v;
      bus.wr    <= 1'b1;
      @(posedge core_clk);
      bus.wr    <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task rd(input byte_t a);
      @(posedge core_clk);
      bus.addr <= a;
      bus.rd   <= 1'b1;
      @(posedge core_clk);
      bus.rd   <= 1'b0;
      #1;
      d = rd_data;
   endtask

   task wait_done;
      for (int i = 0; i < 40 && conv_in.done !== 1'b1; i++) begin
         @(posedge core_clk);
      end
      repeat (2) @(posedge core_clk);
   endtask

   task run_conv(input logic [RESULT_W-1:0] v);
      val <= v;
      lat <= 4'($urandom_range(9, 0));
      wr(OFS_CTRL_A, 8'hC0);
      wait_done;
   endtask

   task irq_chk(input logic e);
      @(posedge core_clk);
      #1;
      `CHK("irq", e, irq)
   endtask

   task flag_chk(input int s, input int e);
      int base;
      base = starts;
      @(posedge core_clk);
      trig_flags[s] <= 1'b1;
      repeat (4) @(posedge core_clk);
      `CHK("starts", e, starts - base)
      wait_done;
      trig_flags[s] <= 1'b0;
   endtask

   initial begin
      logic [RESULT_W-1:0] v0;
      logic [15:0]         x;
      byte_t               m;
      byte_t               p;
      byte_t               ra [10];
      int                  n;
      ra = '{OFS_CTRL_A, OFS_CHAN, OFS_RES_LOW, OFS_RES_HIGH, OFS_CTRL_B,
             OFS_PIN_OFF, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_PIN_IN, 8'h3C};
      void'($urandom(32'hE7AC));
      rst_n = 1'b0;
      bus = '0;
      trig_flags = '0;
      pin_raw = '0;
      lat = '0;
      val = '0;
      repeat (16) @(posedge core_clk);
      rst_n <= 1'b1;
      foreach (ra[i]) begin
         rd(ra[i]);
         `CHK("reset", 8'h00, d)
      end
      for (n = 0; n < 4; n++) begin
         v0 = (n == 0) ? 10'h3FF : RESULT_W'($urandom);
         run_conv(v0);
         rd(OFS_CTRL_A);
         `CHK("done_flag", 1'b1, d[CA_DONE])
         wr(OFS_CTRL_A, 8'h90);
         wr(OFS_CHAN, (byte_t'(n[0]) << CH_LEFT) | byte_t'(n));
         #1;
         `CHK("chan_sel", CH_MUX_W'(n), chan_select)
         x = fmt(v0, n[0]);
         rd(OFS_RES_LOW);
         `CHK("low", x[7:0], d)
         rd(OFS_RES_HIGH);
         `CHK("high", x[15:8], d)
         wr(OFS_CHAN, byte_t'(!n[0]) << CH_LEFT);
         x = fmt(v0, !n[0]);
         rd(OFS_RES_HIGH);
         `CHK("realign", x[15:8], d)
      end
      // pair locked by the low read while a new result lands
      wr(OFS_IRQ_STAT, 8'h03);
      wr(OFS_RES_LOW, 8'hA5);
      rd(OFS_RES_LOW);
      `CHK("ro_low", v0[7:0], d)
      run_conv(~v0);
      rd(OFS_RES_HIGH);
      `CHK("locked", {6'h00, v0[9:8]}, d)
      rd(OFS_IRQ_STAT);
      `CHK("dropped", 1'b1, d[IRQ_DROP])
      rd(OFS_RES_LOW);
      `CHK("kept", v0[7:0], d)
      rd(OFS_RES_HIGH);
      run_conv(~v0);
      x = fmt(~v0, 1'b0);
      rd(OFS_RES_LOW);
      `CHK("unlock_lo", x[7:0], d)
      rd(OFS_RES_HIGH);
      `CHK("unlock_hi", x[15:8], d)
      wr(OFS_CTRL_A, 8'h90);
      wr(OFS_IRQ_STAT, 8'h03);
      wr(OFS_IRQ_MASK, 8'h01);
      irq_chk(1'b0);
      run_conv(10'h155);
      irq_chk(1'b1);
      wr(OFS_IRQ_MASK, 8'h02);
      irq_chk(1'b0);
      wr(OFS_IRQ_MASK, 8'h01);
      irq_chk(1'b1);
      wr(OFS_IRQ_STAT, 8'h01);
      irq_chk(1'b0);
      wr(OFS_CTRL_A, 8'hB0);
      for (n = 1; n < 8; n++) begin
         wr(OFS_CTRL_B, byte_t'(n));
         rd(OFS_CTRL_B);
         `CHK("ctrl_b", byte_t'(n), d)
         flag_chk(n, 1);
      end
      wr(OFS_CTRL_A, 8'h80);
      flag_chk(7, 0);
      wr(OFS_CTRL_A, 8'hA0);
      wr(OFS_CTRL_B, 8'h01);
      n = starts;
      @(posedge core_clk);
      trig_flags[2] <= 1'b1;
      wr(OFS_CTRL_B, 8'h02);
      repeat (3) @(posedge core_clk);
      `CHK("switch", 1, starts - n)
      wait_done;
      trig_flags[2] <= 1'b0;
      repeat (2) @(posedge core_clk);
      n = starts;
      wr(OFS_CTRL_B, 8'h00);
      repeat (4) @(posedge core_clk);
      `CHK("to_free", 0, starts - n)
      wr(OFS_CTRL_A, 8'hB0);
      n = starts;
      wr(OFS_CTRL_A, 8'hE0);
      wait_done;
      wait_done;
      `CHK("free_run", 2, starts - n)
      for (n = 0; n < 4; n++) begin
         m = (n == 0) ? 8'hFF : (n == 1) ? 8'h00 : byte_t'($urandom);
         p = byte_t'($urandom);
         wr(OFS_PIN_OFF, m);
         pin_raw <= p;
         repeat (6) @(posedge core_clk);
         #1;
         `CHK("buf_off", m, pin_buffer_off)
         `CHK("pin_val", p & ~m, pin_value)
         rd(OFS_PIN_IN);
         `CHK("pin_reg", p & ~m, d)
      end
      `CHK("conv_on", 1'b1, conv_enable)
      wr(OFS_CTRL_A, 8'h00);
      #1;
      `CHK("conv_off", 1'b0, conv_enable)
      stop_test;
   end
endmodule
